// ---- bss_pkg.sv ----
package bss_pkg;

	// ---------------------------------------------------------------
	// Boot modes
	// ---------------------------------------------------------------
	typedef enum logic [2:0]
	{
		BSS_MODE_NONE,
		BSS_MODE_EPROM,
		BSS_MODE_HOST,
		BSS_MODE_LINK,
		BSS_MODE_RESERVED
	} bss_mode_e;

	// ---------------------------------------------------------------
	// Constants
	// ---------------------------------------------------------------
	localparam int BSS_CLK_PERIOD_NS = 10;
	localparam int BSS_SYNC_STAGES = 2;
	localparam int BSS_EPROM_WIDTH = 8;
	localparam int BSS_HOST_WIDE = 32;
	localparam int BSS_HOST_NARROW = 16;
	localparam int BSS_VEC_WIDTH = 32;
	localparam logic [31:0] BSS_RESET_VECTOR = 32'h0002_0004;
	localparam logic [1:0] BSS_CNT_MAX = 2'h3;

endpackage : bss_pkg

// ---- bss_sync_if.sv ----
`timescale 1ns/1ns
interface bss_sync_if;
	logic [2:0] raw;
	logic [2:0] synced;
	modport src (output raw, input synced);
	modport dst (input raw, output synced);
endinterface : bss_sync_if

// ---- bss_sync.sv ----
`timescale 1ns/1ns
module bss_sync
(
	input wire logic clk,
	input wire logic rst_n,
	bss_sync_if.dst sif
);

	// ---------------------------------------------------------------
	// Two-stage synchroniser per strap bit
	// ---------------------------------------------------------------
	logic [2:0] meta_reg;
	logic [2:0] meta_next;
	logic [2:0] sync_reg;
	logic [2:0] sync_next;

	always_comb
	begin
		meta_next = sif.raw;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= 3'h0;
			sync_reg <= 3'h0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sif.synced = sync_reg;

endmodule : bss_sync

// ---- bss_boot_selector.sv ----
`timescale 1ns/1ns
// Operation
// - Eprom strap high with link strap low selects byte-wide EPROM boot load.
// - Eprom strap low: link strap and select input choose the mode.
// - Straps 0,0 with select 1 selects host processor boot.
// - Straps 0,1 with select 1 selects link port boot.
// - Straps 0,0 with select 0: no boot, fetch from external memory.
// - EPROM mode drives the select pin as EPROM chip select.
// - Only the current bus owner drives the select output.
// - Select pin three-statable only in EPROM boot mode.
// - Host boot supports 32-bit and 16-bit hosts.
// - Reset gives known state, then start at reset vector; reserved straps flag an error and never start.
// - Instruction rate equals input clock, no multiply or divide.
module bss_boot_selector
#(
	parameter logic [31:0] RESET_VECTOR = bss_pkg::BSS_RESET_VECTOR
)
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic EPROM_BOOT_STRAP,
	input wire logic LINK_BOOT_STRAP,
	input wire logic BOOT_MEMORY_SELECT_I,
	output logic BOOT_MEMORY_SELECT_O,
	output logic BOOT_MEMORY_SELECT_OE_N,
	input wire logic BUS_MASTER,
	input wire logic EPROM_CS_REQ,
	input wire logic HOST_WIDE,
	input wire logic BOOT_DONE,
	output logic [2:0] BOOT_MODE,
	output logic BOOT_EPROM,
	output logic BOOT_HOST,
	output logic BOOT_HOST_WIDE,
	output logic BOOT_LINK,
	output logic BOOT_NONE,
	output logic CONFIG_ERROR,
	output logic BOOT_ACTIVE,
	output logic START_EXEC,
	output logic [31:0] START_ADDR,
	output logic INSTR_TICK
);

	// ---------------------------------------------------------------
	// Strap synchronisation
	// ---------------------------------------------------------------
	bss_sync_if sif();

	assign sif.raw = {EPROM_BOOT_STRAP, LINK_BOOT_STRAP,
		BOOT_MEMORY_SELECT_I};

	bss_sync u_sync
	(
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.sif(sif.dst)
	);

	logic eb;
	logic lb;
	logic bs;
	assign eb = sif.synced[2];
	assign lb = sif.synced[1];
	assign bs = sif.synced[0];

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	bss_pkg::bss_mode_e dec_mode;

	always_comb
	begin
		if (eb && !lb)
			dec_mode = bss_pkg::BSS_MODE_EPROM;
		else if (eb)
			dec_mode = bss_pkg::BSS_MODE_RESERVED;
		else if (!lb && bs)
			dec_mode = bss_pkg::BSS_MODE_HOST;
		else if (lb && bs)
			dec_mode = bss_pkg::BSS_MODE_LINK;
		else if (!lb)
			dec_mode = bss_pkg::BSS_MODE_NONE;
		else
			dec_mode = bss_pkg::BSS_MODE_RESERVED;
	end

	// ---------------------------------------------------------------
	// Capture window and latched mode
	// ---------------------------------------------------------------
	// Straps settle through the synchroniser after reset release, so
	// the mode is captured once the pipeline has filled.
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic locked_reg;
	logic locked_next;
	bss_pkg::bss_mode_e mode_reg;
	bss_pkg::bss_mode_e mode_next;
	logic wide_reg;
	logic wide_next;
	logic active_reg;
	logic active_next;
	logic start_reg;
	logic start_next;
	logic capture;

	assign capture = !locked_reg && (cnt_reg == bss_pkg::BSS_CNT_MAX);

	always_comb
	begin
		cnt_next = cnt_reg;
		locked_next = locked_reg;
		mode_next = mode_reg;
		wide_next = wide_reg;
		active_next = active_reg;
		start_next = start_reg;
		if (!locked_reg && cnt_reg != bss_pkg::BSS_CNT_MAX)
			cnt_next = cnt_reg + 2'h1;
		if (capture)
		begin
			locked_next = 1'b1;
			mode_next = dec_mode;
			wide_next = HOST_WIDE;
			active_next = (dec_mode == bss_pkg::BSS_MODE_EPROM)
				|| (dec_mode == bss_pkg::BSS_MODE_HOST)
				|| (dec_mode == bss_pkg::BSS_MODE_LINK);
			start_next = (dec_mode == bss_pkg::BSS_MODE_NONE);
		end
		else if (active_reg && BOOT_DONE)
		begin
			active_next = 1'b0;
			start_next = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cnt_reg <= 2'h0;
			locked_reg <= 1'b0;
			mode_reg <= bss_pkg::BSS_MODE_NONE;
			wide_reg <= 1'b0;
			active_reg <= 1'b0;
			start_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			locked_reg <= locked_next;
			mode_reg <= mode_next;
			wide_reg <= wide_next;
			active_reg <= active_next;
			start_reg <= start_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	logic sel_o_reg;
	logic sel_o_next;
	logic sel_oe_n_reg;
	logic sel_oe_n_next;
	logic [31:0] addr_reg;
	logic [31:0] addr_next;
	logic tick_reg;
	logic tick_next;
	logic eprom_reg;
	logic eprom_next;
	logic host_reg;
	logic host_next;
	logic link_reg;
	logic link_next;
	logic none_reg;
	logic none_next;
	logic err_reg;
	logic err_next;
	logic is_eprom;

	assign is_eprom = locked_reg && mode_reg == bss_pkg::BSS_MODE_EPROM;

	always_comb
	begin
		// Chip select is active low; idle high
		sel_o_next = !(is_eprom && BUS_MASTER && EPROM_CS_REQ);
		sel_oe_n_next = !(is_eprom && BUS_MASTER);
		addr_next = start_next ? RESET_VECTOR : 32'h0000_0000;
		tick_next = locked_reg;
		eprom_next = active_next
			&& mode_next == bss_pkg::BSS_MODE_EPROM;
		host_next = active_next
			&& mode_next == bss_pkg::BSS_MODE_HOST;
		link_next = active_next
			&& mode_next == bss_pkg::BSS_MODE_LINK;
		none_next = locked_next
			&& mode_next == bss_pkg::BSS_MODE_NONE;
		err_next = locked_next
			&& mode_next == bss_pkg::BSS_MODE_RESERVED;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sel_o_reg <= 1'b1;
			sel_oe_n_reg <= 1'b1;
			addr_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
			eprom_reg <= 1'b0;
			host_reg <= 1'b0;
			link_reg <= 1'b0;
			none_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else
		begin
			sel_o_reg <= sel_o_next;
			sel_oe_n_reg <= sel_oe_n_next;
			addr_reg <= addr_next;
			tick_reg <= tick_next;
			eprom_reg <= eprom_next;
			host_reg <= host_next;
			link_reg <= link_next;
			none_reg <= none_next;
			err_reg <= err_next;
		end
	end

	assign BOOT_MEMORY_SELECT_O = sel_o_reg;
	assign BOOT_MEMORY_SELECT_OE_N = sel_oe_n_reg;
	assign BOOT_MODE = mode_reg;
	assign BOOT_EPROM = eprom_reg;
	assign BOOT_HOST = host_reg;
	assign BOOT_HOST_WIDE = wide_reg;
	assign BOOT_LINK = link_reg;
	assign BOOT_NONE = none_reg;
	assign CONFIG_ERROR = err_reg;
	assign BOOT_ACTIVE = active_reg;
	assign START_EXEC = start_reg;
	assign START_ADDR = addr_reg;
	assign INSTR_TICK = tick_reg;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	a_mode_held: assert property (locked_reg |=> $stable(mode_reg))
		else $error("Boot mode changed after capture");
	sequence s_noboot_start;
		START_EXEC ##1 START_ADDR == RESET_VECTOR;
	endsequence
	sequence s_reserved_hold;
		CONFIG_ERROR && !BOOT_ACTIVE ##1 !START_EXEC;
	endsequence

	a_sel_eprom_only: assert property
		(!BOOT_MEMORY_SELECT_OE_N |-> mode_reg == bss_pkg::BSS_MODE_EPROM)
		else $error("Select pin driven outside EPROM mode");
	a_sel_owner: assert property
		(!BUS_MASTER |=> BOOT_MEMORY_SELECT_OE_N)
		else $error("Select pin driven by non-owner");
	a_eprom_decode: assert property (capture && eb && !lb
		|=> mode_reg == bss_pkg::BSS_MODE_EPROM && active_reg)
		else $error("EPROM strap not decoded");
	a_host_decode: assert property (capture && !eb && !lb && bs
		|=> BOOT_HOST)
		else $error("Host boot not decoded");
	a_link_decode: assert property (capture && !eb && lb && bs
		|=> BOOT_LINK)
		else $error("Link boot not decoded");
	a_noboot_start: assert property (capture && !eb && !lb && !bs
		|=> s_noboot_start)
		else $error("No-boot start missing");
	a_reserved_err: assert property (capture && lb && (eb || !bs)
		|=> s_reserved_hold)
		else $error("Reserved straps not flagged");
	a_done_start: assert property (active_reg && BOOT_DONE && !capture
		|=> START_EXEC && !BOOT_ACTIVE)
		else $error("Boot end did not start execution");
	a_tick_rate: assert property (locked_reg |=> INSTR_TICK)
		else $error("Instruction tick missing");

endmodule : bss_boot_selector

// ---- bss_boot_partner.sv ----
`timescale 1ns/1ns
module bss_boot_partner
#(
	parameter int LOAD_CYCLES = 5
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic boot_active,
	input wire logic sel_o,
	input wire logic sel_oe_n,
	input wire logic sel_strap,
	output logic sel_pin,
	output logic boot_done
);
	int cnt;
	// Pin level: driven select, else board tie level
	assign sel_pin = sel_oe_n ? sel_strap : sel_o;
	// Loader answers after a load time, only while asked
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			boot_done <= 1'b0;
		end
		else if (boot_active && cnt < LOAD_CYCLES)
		begin
			cnt <= cnt + 1;
			boot_done <= 1'b0;
		end
		else
			boot_done <= boot_active;
	end
endmodule : bss_boot_partner

// ---- test_bss_boot_selector.sv ----
`timescale 1ns/1ns
module test_bss_boot_selector;
	localparam logic [31:0] VEC = 32'h0000_1A2C;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic ebs = 1'b0;
	logic lbs = 1'b0;
	logic sel_strap = 1'b1;
	logic host_wide = 1'b0;
	logic bus_master = 1'b0;
	logic eprom_cs_req = 1'b0;
	logic sel_pin, sel_o, oe_n, boot_done, b_eprom, b_host, b_link;
	logic b_wide, b_none, cfg_err, b_act, start_exec, tick;
	logic [2:0] boot_mode;
	logic [31:0] start_addr;
	int error_cnt = 0;
	int checks_done = 0;
	bss_boot_selector #(.RESET_VECTOR(VEC)) bss_boot_selector_i (
		.CLK_SYS(clk_sys), .RST_N(rst_n), .EPROM_BOOT_STRAP(ebs),
		.LINK_BOOT_STRAP(lbs), .BOOT_MEMORY_SELECT_I(sel_pin),
		.BOOT_MEMORY_SELECT_O(sel_o), .BOOT_MEMORY_SELECT_OE_N(oe_n),
		.BUS_MASTER(bus_master), .EPROM_CS_REQ(eprom_cs_req),
		.HOST_WIDE(host_wide), .BOOT_DONE(boot_done),
		.BOOT_MODE(boot_mode), .BOOT_EPROM(b_eprom), .BOOT_HOST(b_host),
		.BOOT_HOST_WIDE(b_wide), .BOOT_LINK(b_link), .BOOT_NONE(b_none),
		.CONFIG_ERROR(cfg_err), .BOOT_ACTIVE(b_act),
		.START_EXEC(start_exec), .START_ADDR(start_addr),
		.INSTR_TICK(tick));
	bss_boot_partner bss_boot_partner_i (.clk(clk_sys), .rst_n(rst_n),
		.boot_active(b_act), .sel_o(sel_o), .sel_oe_n(oe_n),
		.sel_strap(sel_strap), .sel_pin(sel_pin), .boot_done(boot_done));
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	// -----------------------------
	// One power-up per strap setting
	// -----------------------------
	task automatic run_case(input logic [3:0] c, input bss_pkg::bss_mode_e m);
		logic ep;
		logic rsv;
		int n;
		ep = (m == bss_pkg::BSS_MODE_EPROM);
		rsv = (m == bss_pkg::BSS_MODE_RESERVED);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		{ebs, lbs, sel_strap, host_wide} <= c;
		bus_master <= 1'b0;
		eprom_cs_req <= 1'b0;
		repeat (12) @(posedge clk_sys);
		chk(boot_mode === 3'h0 && start_exec === 1'b0, "reset");
		chk(oe_n === 1'b1 && sel_o === 1'b1, "reset sel");
		chk(start_addr === 32'h0 && b_act === 1'b0, "reset addr");
		rst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(boot_mode === m, "mode");
		chk(cfg_err === rsv, "cfg err");
		chk(b_act === (!rsv && m != bss_pkg::BSS_MODE_NONE), "act");
		chk(b_eprom === ep, "eprom flag");
		chk(b_host === (m == bss_pkg::BSS_MODE_HOST), "host flag");
		chk(b_link === (m == bss_pkg::BSS_MODE_LINK), "link flag");
		chk(b_none === (m == bss_pkg::BSS_MODE_NONE), "none");
		chk(m != bss_pkg::BSS_MODE_HOST || b_wide === c[0], "wide");
		chk(tick === 1'b1, "tick");
		@(posedge clk_sys);
		{ebs, lbs, sel_strap} <= ~c[3:1];
		bus_master <= 1'b1;
		eprom_cs_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(boot_mode === m, "mode held");
		chk(oe_n === !ep && sel_o === !ep, "sel drive");
		@(posedge clk_sys);
		bus_master <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(oe_n === 1'b1 && sel_o === 1'b1, "sel owner");
		n = 0;
		while (start_exec !== 1'b1 && n < 40)
		begin
			@(negedge clk_sys);
			n++;
		end
		chk(start_exec === !rsv, "start");
		@(negedge clk_sys);
		chk(b_act === 1'b0, "idle");
		chk(start_addr === (rsv ? 32'h0 : VEC), "addr");
	endtask : run_case
	initial
	begin
		#50000;
		error_cnt++;
		end_sim();
	end
	initial
	begin
		run_case(4'b1000, bss_pkg::BSS_MODE_EPROM);
		run_case(4'b0011, bss_pkg::BSS_MODE_HOST);
		run_case(4'b0010, bss_pkg::BSS_MODE_HOST);
		run_case(4'b0110, bss_pkg::BSS_MODE_LINK);
		run_case(4'b0000, bss_pkg::BSS_MODE_NONE);
		run_case(4'b0100, bss_pkg::BSS_MODE_RESERVED);
		run_case(4'b1100, bss_pkg::BSS_MODE_RESERVED);
		end_sim();
	end
endmodule : test_bss_boot_selector
